//--- rtl/virtual_counter_pwm.sv
`timescale 1ns/1ps
// What this block does
// R1 - Program fits loop slot count, software's duty
// R2 - Loop period is loop ratio fine periods
// R3 - Fine ratio one ticks every clock
// R4 - Each instruction takes one slot
// R5 - Virtual count executes once per loop
// R6 - Count increments data, copies to register
// R7 - After limit the count returns to zero
// R8 - Next pointer chains instructions, no counter
// R9 - Compare field: fine bits 6..0, coarse above
// R10 - Use only upper log2 loop-ratio fine bits
// R11 - Software shifts fine compare time itself
// R12 - Compare coarse value against selected register
// R13 - Match with action enabled drives chosen pin; code drives it only when the pulse-high action bit is also set
// R14 - Pulse high: set on match, clear on wrap
// R15 - Fine select delays set by fine field
// R16 - Instruction is four 32-bit words
// R17 - Host loads memory before engine starts
// R18 - Fine delay counts from loop period start; code counts from the compare slot
module virtual_counter_pwm (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [7:0]  address,
   input  wire logic [31:0] write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   output logic      [31:0] read_data,
   output logic      [7:0]  pin_out
);
   localparam int RW = vc_pwm_pkg::REG_WIDTH;
   localparam int PN = vc_pwm_pkg::PIN_COUNT;

   logic [31:0]    mem [0:4*vc_pwm_pkg::INSTR_COUNT-1];
   logic           enable_reg;
   logic [5:0]     fine_code_reg;
   logic [2:0]     loop_code_reg;
   logic           overrun_reg;
   logic [5:0]     fine_cnt_reg;
   logic [6:0]     loop_cnt_reg;
   logic           fine_tick;
   logic           loop_tick;
   vc_pwm_pkg::state_type state_reg;
   logic [2:0]     ptr_reg;
   logic [RW-1:0]  reg_file [0:1];
   logic [1:0]     wrap_reg;
   vc_pwm_pkg::instr_type instr;
   logic           exec;
   logic           exec_count;
   logic           exec_cmp;
   logic [RW-1:0]  count_next;
   logic           count_wrap;
   logic [PN-1:0]  set_hit;
   logic [PN-1:0]  clr_hit;
   logic [6:0]     set_delay;
   logic [PN-1:0]  pin_reg;

   // ****************************************************
   // Helpers
   // ****************************************************
   // Upper log2(loop ratio) bits of the fine field form the delay
   function automatic logic [6:0] fine_delay(input logic [6:0] f,
                                             input logic [2:0] code);
      fine_delay = f >> (3'h7 - code); // see R10
   endfunction

   // Address falls inside instruction memory
   function automatic logic is_mem(input logic [7:0] a);
      is_mem = (a <= vc_pwm_pkg::ADDR_MEM_LAST);
   endfunction

   // ****************************************************
   // Register port
   // ****************************************************
   // Control: engine enable
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         enable_reg <= 1'b0;
      end else if (write_strobe &&
                   address == vc_pwm_pkg::ADDR_CONTROL) begin
         enable_reg <= write_data[0];
      end
   end

   // Prescale only changes while stopped so periods stay whole
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fine_code_reg <= vc_pwm_pkg::FINE_CODE_RESET;
         loop_code_reg <= vc_pwm_pkg::LOOP_CODE_RESET;
      end else if (write_strobe && !enable_reg &&
                   address == vc_pwm_pkg::ADDR_PRESCALE) begin
         fine_code_reg <= write_data[vc_pwm_pkg::FINE_CODE_LSB +: 6];
         loop_code_reg <= write_data[vc_pwm_pkg::LOOP_CODE_LSB +: 3];
      end
   end

   // Overrun is sticky; a new overrun wins over write-one-clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         overrun_reg <= 1'b0;
      end else if (loop_tick && state_reg == vc_pwm_pkg::state_run) begin
         overrun_reg <= 1'b1; // see R1
      end else if (write_strobe &&
                   address == vc_pwm_pkg::ADDR_STATUS &&
                   write_data[vc_pwm_pkg::STATUS_OVERRUN]) begin
         overrun_reg <= 1'b0;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         read_data <= 32'h0000_0000;
      end else if (!read_strobe) begin
         read_data <= 32'h0000_0000;
      end else if (is_mem(address)) begin
         read_data <= mem[address[6:2]];
      end else begin
         case (address)
            vc_pwm_pkg::ADDR_CONTROL: read_data <= {31'h0, enable_reg};
            vc_pwm_pkg::ADDR_PRESCALE:
               read_data <= {21'h0, loop_code_reg, 2'h0, fine_code_reg};
            vc_pwm_pkg::ADDR_STATUS:
               read_data <= {16'h0, pin_reg, 7'h0, overrun_reg};
            vc_pwm_pkg::ADDR_REG_A: read_data <= {7'h0, reg_file[0]};
            vc_pwm_pkg::ADDR_REG_B: read_data <= {7'h0, reg_file[1]};
            default: read_data <= 32'h0000_0000;
         endcase
      end
   end

   // Four words per instruction; host writes only while stopped
   always_ff @(posedge clock) begin
      if (exec_count) begin
         mem[{ptr_reg, vc_pwm_pkg::WORD_DATA}] <= {7'h0, count_next}; // see R6
      end else if (write_strobe && !enable_reg && is_mem(address)) begin
         mem[address[6:2]] <= write_data; // see R16 R17
      end
   end

   // ****************************************************
   // Prescalers
   // ****************************************************
   // Fine ratio is code plus one clocks; code zero ticks each clock
   assign fine_tick = enable_reg && fine_cnt_reg == fine_code_reg; // see R3
   assign loop_tick = fine_tick &&
                      loop_cnt_reg == 7'((8'h01 << loop_code_reg) - 8'h01);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fine_cnt_reg <= 6'h00;
         loop_cnt_reg <= 7'h00;
      end else if (!enable_reg) begin
         fine_cnt_reg <= 6'h00;
         loop_cnt_reg <= 7'h00;
      end else if (fine_tick) begin
         fine_cnt_reg <= 6'h00;
         loop_cnt_reg <= loop_tick ? 7'h00 : loop_cnt_reg + 7'h01; // see R2
      end else begin
         fine_cnt_reg <= fine_cnt_reg + 6'h01;
      end
   end

   // ****************************************************
   // Sequencer
   // ****************************************************
   // Decode the instruction at the pointer
   always_comb begin
      instr = '0;
      instr.next_ptr    = mem[{ptr_reg, vc_pwm_pkg::WORD_PROGRAM}][2:0];
      instr.opcode      = mem[{ptr_reg, vc_pwm_pkg::WORD_PROGRAM}][4:3];
      instr.reg_sel     = mem[{ptr_reg, vc_pwm_pkg::WORD_PROGRAM}][5];
      instr.count_limit = mem[{ptr_reg, vc_pwm_pkg::WORD_CONTROL}][RW-1:0];
      instr.pin_action_enable  = mem[{ptr_reg, vc_pwm_pkg::WORD_CONTROL}][0];
      instr.fine_coarse_select = mem[{ptr_reg, vc_pwm_pkg::WORD_CONTROL}][1];
      instr.pulse_high_action  = mem[{ptr_reg, vc_pwm_pkg::WORD_CONTROL}][2];
      instr.pin_sel     = mem[{ptr_reg, vc_pwm_pkg::WORD_CONTROL}][5:3];
      instr.data_field  = mem[{ptr_reg, vc_pwm_pkg::WORD_DATA}];
   end

   assign exec = state_reg == vc_pwm_pkg::state_run;
   assign exec_count = exec && instr.opcode == vc_pwm_pkg::OP_VIRTUAL_COUNT;
   assign exec_cmp   = exec && instr.opcode == vc_pwm_pkg::OP_MAGNITUDE_CMP;

   // Wrap to zero on the execution after the limit
   assign count_wrap = instr.data_field[RW-1:0] == instr.count_limit;
   assign count_next = count_wrap ? '0 : instr.data_field[RW-1:0] + RW'(1); // see R7

   // Each loop starts at slot zero; a pointer back to zero ends it
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= vc_pwm_pkg::state_idle;
         ptr_reg   <= 3'h0;
      end else if (loop_tick) begin
         state_reg <= vc_pwm_pkg::state_run;
         ptr_reg   <= 3'h0;
      end else begin
         case (state_reg)
            vc_pwm_pkg::state_run: begin
               ptr_reg <= instr.next_ptr; // see R4 R8
               if (instr.next_ptr == 3'h0 || !enable_reg) begin
                  state_reg <= vc_pwm_pkg::state_idle; // see R5
               end
            end
            default: state_reg <= vc_pwm_pkg::state_idle;
         endcase
      end
   end

   // Internal registers take the new count
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_file[0] <= '0;
         reg_file[1] <= '0;
      end else if (exec_count) begin
         reg_file[instr.reg_sel] <= count_next; // see R6
      end
   end

   // Wrap seen this loop, consumed by compares on the same register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wrap_reg <= 2'h0;
      end else if (exec_count) begin
         wrap_reg[instr.reg_sel] <= count_wrap;
      end else if (loop_tick) begin
         wrap_reg <= 2'h0;
      end
   end

   // ****************************************************
   // Compare and pin actions
   // ****************************************************
   // Coarse part is bits 31..7, fine part bits 6..0
   always_comb begin
      set_hit = '0;
      clr_hit = '0;
      set_delay = '0;
      if (exec_cmp && instr.pin_action_enable &&
          instr.pulse_high_action) begin // see R13
         if (reg_file[instr.reg_sel] >= instr.data_field[31:7]) begin // see R9 R12
            set_hit[instr.pin_sel] = 1'b1; // see R14
         end
         if (wrap_reg[instr.reg_sel]) begin
            clr_hit[instr.pin_sel] = 1'b1; // see R14
         end
      end
      if (instr.fine_coarse_select) begin
         set_delay = fine_delay(instr.data_field[6:0], loop_code_reg); // see R15
      end
   end

   // One fine delay counter per pin, loaded by the compare and counted in fine ticks after it
   genvar g;
   generate
      for (g = 0; g < PN; g++) begin : g_pin
         logic       pend_reg;
         logic [6:0] dly_reg;
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               pin_reg[g] <= 1'b0;
               pend_reg   <= 1'b0;
               dly_reg    <= 7'h00;
            end else if (set_hit[g] && set_delay == 7'h00) begin
               pin_reg[g] <= 1'b1;
               pend_reg   <= 1'b0;
            end else if (set_hit[g]) begin
               if (clr_hit[g]) begin
                  pin_reg[g] <= 1'b0;
               end
               pend_reg <= 1'b1;
               dly_reg  <= set_delay; // see R18
            end else if (clr_hit[g]) begin
               pin_reg[g] <= 1'b0;
               pend_reg   <= 1'b0;
            end else if (pend_reg && fine_tick) begin
               if (dly_reg == 7'h01) begin
                  pin_reg[g] <= 1'b1; // see R15
                  pend_reg   <= 1'b0;
               end
               dly_reg <= dly_reg - 7'h01;
            end
         end
      end
   endgenerate

   assign pin_out = pin_reg;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   logic [13:0] since_loop_reg;
   logic        seen_loop_reg;
   logic        counted_reg;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         since_loop_reg <= 14'h0000;
         seen_loop_reg  <= 1'b0;
         counted_reg    <= 1'b0;
      end else begin
         since_loop_reg <= loop_tick ? 14'h0000 : since_loop_reg + 14'h0001;
         seen_loop_reg  <= enable_reg && (seen_loop_reg || loop_tick);
         counted_reg    <= !loop_tick && (counted_reg || exec_count);
      end
   end

   chk_fine_every_clock: assert property ( // see R3
      enable_reg && fine_code_reg == 6'h00 |-> fine_tick)
      else $error("fine tick missing at ratio one");
   chk_loop_period_len: assert property ( // see R2
      loop_tick && seen_loop_reg |-> since_loop_reg ==
      14'(((15'h0001 << loop_code_reg) * (fine_code_reg + 15'h0001))
          - 15'h0001))
      else $error("loop period length wrong");
   chk_count_once: assert property ( // see R5
      exec_count |-> !counted_reg)
      else $error("virtual count ran twice in a loop");
   chk_count_copy: assert property ( // see R6
      exec_count |=> reg_file[$past(instr.reg_sel)] ==
      mem[{$past(ptr_reg), vc_pwm_pkg::WORD_DATA}][RW-1:0])
      else $error("register not equal to count");
   chk_count_wrap: assert property ( // see R7
      exec_count && count_wrap |=> reg_file[$past(instr.reg_sel)] == '0)
      else $error("count did not wrap to zero");
   chk_next_pointer: assert property ( // see R8
      exec && !loop_tick |=> ptr_reg == $past(instr.next_ptr))
      else $error("pointer not taken from instruction");
   chk_pin_set: assert property ( // see R14
      set_hit[0] && set_delay == 7'h00 |=> pin_out[0])
      else $error("pin not set on match");
   chk_pin_clear: assert property ( // see R14
      clr_hit[0] && !set_hit[0] |=> !pin_out[0] ##1 !pin_out[0] [*1])
      else $error("pin not cleared on wrap");
   chk_fine_delay: assert property ( // see R15
      set_hit[0] && set_delay != 7'h00 && !pin_out[0] |=> !pin_out[0])
      else $error("fine delay not applied");

   cov_wrap: cover property (exec_count && count_wrap);
   cov_set_delayed: cover property (set_hit[0] && set_delay != 7'h00);
   cov_rise: cover property (!pin_out[0] ##1 pin_out[0]);
   cov_overrun: cover property (loop_tick && exec);
endmodule

//--- rtl/vc_pwm_pkg.sv
package vc_pwm_pkg;
   // ****************************************************
   // Sizes
   // ****************************************************
   localparam int INSTR_COUNT = 8;
   localparam int PIN_COUNT   = 8;
   localparam int REG_WIDTH   = 25;
   localparam int FINE_WIDTH  = 7;
   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam logic [7:0] ADDR_MEM_LAST  = 8'h7C;
   localparam logic [7:0] ADDR_CONTROL   = 8'h80;
   localparam logic [7:0] ADDR_PRESCALE  = 8'h84;
   localparam logic [7:0] ADDR_STATUS    = 8'h88;
   localparam logic [7:0] ADDR_REG_A     = 8'h8C;
   localparam logic [7:0] ADDR_REG_B     = 8'h90;
   // Word index inside one four-word instruction
   localparam logic [1:0] WORD_PROGRAM   = 2'h0;
   localparam logic [1:0] WORD_CONTROL   = 2'h1;
   localparam logic [1:0] WORD_DATA      = 2'h2;
   // Prescale field positions and reset values
   localparam int FINE_CODE_LSB          = 0;
   localparam int LOOP_CODE_LSB          = 8;
   localparam logic [5:0] FINE_CODE_RESET = 6'h00;
   localparam logic [2:0] LOOP_CODE_RESET = 3'h3;
   localparam int LOOP_CODE_MAX          = 7;
   // Status field positions
   localparam int STATUS_OVERRUN         = 0;
   localparam int STATUS_PINS_LSB        = 8;
   // ****************************************************
   // Instruction encoding
   // ****************************************************
   localparam logic [1:0] OP_VIRTUAL_COUNT = 2'h1;
   localparam logic [1:0] OP_MAGNITUDE_CMP = 2'h2;
   typedef enum logic {
      state_idle = 1'b0,
      state_run  = 1'b1
   } state_type;
   // Decoded fields of the instruction at the sequencer pointer
   typedef struct packed {
      logic [2:0]           next_ptr;
      logic [1:0]           opcode;
      logic                 reg_sel;
      logic [REG_WIDTH-1:0] count_limit;
      logic                 pin_action_enable;
      logic                 fine_coarse_select;
      logic                 pulse_high_action;
      logic [2:0]           pin_sel;
      logic [31:0]          data_field;
   } instr_type;
endpackage

//--- verif/pin_load_model.sv
`timescale 1ns/1ps
// ****************************************************
// Load on one timer pin
// ****************************************************
// Measures pulse period and high time, in clocks, on the selected pin
module pin_load_model (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [7:0]  pin_out,
   input  wire logic [2:0]  pin_sel,
   output logic      [31:0] period_count,
   output logic      [31:0] high_count,
   output logic      [31:0] rise_total
);
   logic        level_reg;
   logic [31:0] span_reg;
   logic        level_now;

   // The load sees only whole-cycle levels, so times are edge counts
   assign level_now = pin_out[pin_sel];

   // Span since the last rise; a rise closes one period, a fall one pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         level_reg <= 1'b0;
         span_reg <= 32'h0;
         period_count <= 32'h0;
         high_count <= 32'h0;
         rise_total <= 32'h0;
      end else begin
         level_reg <= level_now;
         span_reg <= span_reg + 32'h1;
         if (level_now && !level_reg) begin
            period_count <= span_reg;
            span_reg <= 32'h1;
            rise_total <= rise_total + 32'h1;
         end
         if (!level_now && level_reg) begin
            high_count <= span_reg;
         end
      end
   end
endmodule

//--- verif/tb_virtual_counter_pwm.sv
`timescale 1ns/1ps
module tb_virtual_counter_pwm;
   logic        clock;
   logic        reset;
   logic [7:0]  address;
   logic [31:0] write_data;
   logic        write_strobe;
   logic        read_strobe;
   logic [31:0] read_data;
   logic [7:0]  pin_out;
   logic [2:0]  pin_sel;
   logic [31:0] period_count;
   logic [31:0] high_count;
   logic [31:0] rise_total;
   logic [31:0] rnd;
   int          fail_count;
   int          num_checks;

   virtual_counter_pwm dut (
      .clock(clock), .reset(reset), .address(address),
      .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data), .pin_out(pin_out));

   pin_load_model load (
      .clock(clock), .reset(reset), .pin_out(pin_out), .pin_sel(pin_sel),
      .period_count(period_count), .high_count(high_count),
      .rise_total(rise_total));

   // ****************************************************
   // Clock, helpers and expectations
   // ****************************************************
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // One pulse period is limit+1 loop periods of loop*fine clocks
   function automatic logic [31:0] exp_period(input int lim, lc, fc);
      return 32'((lim + 1) * (1 << lc) * (fc + 1));
   endfunction

   // High from the first loop at or above coarse until the wrap loop,
   // shortened by the fine delay; low bits under the loop ratio ignored
   function automatic logic [31:0] exp_high(input int lim, crs, fine, lc, fc);
      int d;
      d = fine >> (7 - lc);
      return 32'(((lim - crs + 1) * (1 << lc) - d) * (fc + 1));
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] expd,
                        input string what);
      num_checks++;
      if (seen !== expd) begin
         fail_count++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, expd);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1;
      d = read_data;
   endtask

   task automatic do_reset();
      @(posedge clock);
      reset <= 1'b1;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ****************************************************
   // One pulse program: count then compare
   // ****************************************************
   // Option bit 0 picks register B, bit 1 turns fine pin control off
   task automatic run_case(input int lim, crs, fine, lc, fc, pin, opt);
      logic [31:0] v;
      logic [31:0] w;
      logic [31:0] cmp_word;
      int          n;
      do_reset();
      pin_sel <= 3'(pin);
      cmp_word = {7'h00, 25'(crs)} << 7 | 32'(fine & 7'h7F);
      wr(vc_pwm_pkg::ADDR_PRESCALE, 32'(lc) << 8 | 32'(fc));
      // Whole image is loaded before the engine starts
      // Two slots fit every loop ratio used here
      wr(8'h00, {26'h0, opt[0], vc_pwm_pkg::OP_VIRTUAL_COUNT, 3'h1});
      wr(8'h04, 32'(lim));
      wr(8'h08, 32'h0);
      wr(8'h10, {26'h0, opt[0], vc_pwm_pkg::OP_MAGNITUDE_CMP, 3'h0});
      wr(8'h14, 32'(pin) << 3 | (opt[1] ? 32'h5 : 32'h7));
      wr(8'h18, cmp_word);
      wr(vc_pwm_pkg::ADDR_CONTROL, 32'h1);
      n = 0;
      while (rise_total < 3 && n < 6000) begin
         @(posedge clock);
         n++;
      end
      check(32'(rise_total >= 3), 32'h1, "no pulses");
      check(period_count, exp_period(lim, lc, fc), "period");
      check(high_count, exp_high(lim, crs, opt[1] ? 0 : fine, lc, fc),
            "high");
      check(32'(pin_out & ~(8'h01 << pin)), 32'h0, "stray pin");
      // Memory is locked while running
      wr(8'h18, ~cmp_word);
      wr(vc_pwm_pkg::ADDR_CONTROL, 32'h0);
      rd(8'h18, v);
      check(v, cmp_word, "memory locked");
      rd(8'h08, v);
      rd(opt[0] ? vc_pwm_pkg::ADDR_REG_B : vc_pwm_pkg::ADDR_REG_A, w);
      check(w, v, "count copy");
      check(32'(v <= 32'(lim)), 32'h1, "count range");
      rd(vc_pwm_pkg::ADDR_STATUS, v);
      check(v & 32'h1, 32'h0, "overrun");
      $display("case limit %0d coarse %0d done", lim, crs);
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      logic [31:0] v;
      int          lc;
      int          fc;
      int          lim;
      reset = 1'b1;
      address = 8'h00;
      write_data = 32'h0;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      pin_sel = 3'h0;
      fail_count = 0;
      num_checks = 0;
      rnd = 32'h0000_0D78;
      do_reset();
      rd(vc_pwm_pkg::ADDR_PRESCALE, v);
      check(v, 32'h0000_0300, "prescale reset");
      @(posedge clock);
      #1;
      check(read_data, 32'h0, "read data held");
      wr(8'hA0, 32'hFFFF_FFFF);
      rd(8'hA0, v);
      check(v, 32'h0, "unmapped");
      $display("reset test done");
      // Fine ratio one, maximum coarse and fine values
      run_case(7, 7, 7'h7F, 3, 0, 0, 0);
      run_case(9, 1, 7'h0F, 3, 0, 7, 0);
      run_case(5, 3, 7'h40, 2, 0, 3, 3);
      for (int i = 0; i < 6; i++) begin
         rnd = next_rand(rnd);
         lc = 2 + int'(rnd[7:0]) % 3;
         fc = rnd[9] ? 0 : int'(rnd[11:10]);
         lim = 2 + int'(rnd[15:12]) % 14;
         run_case(lim, 1 + int'(rnd[23:16]) % lim,
                  fc == 0 ? int'(rnd[30:24]) : 0, lc, fc, int'(rnd[2:0]),
                  int'(rnd[4:3]));
      end
      end_sim();
   end

   // Worst case is nine programs of a few thousand clocks each
   initial begin
      repeat (80000) @(posedge clock);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end
endmodule
